// file: option_pkg.sv
// constants and types shared by the option byte decoder
package option_pkg;

  // ==========================================
  // register map
  localparam logic [11:0] OPT_ADDR_NATIVE = 12'hf00;
  localparam logic [11:0] OPT_ADDR_EMUL = 12'h700;
  localparam logic [11:0] CTRL_ADDR = 12'h010;
  localparam logic [11:0] STATUS_ADDR = 12'h014;
  localparam int ADDR_W = 12;

  // ==========================================
  // option byte layout
  localparam logic [7:0] OPT_ERASED = 8'h00;
  localparam int OPT_WDT_BIT = 0;
  localparam int OPT_IRQ_BIT = 1;
  localparam int OPT_EMUL_BIT = 2;
  localparam int OPT_W = 8;

  // ==========================================
  // control and status layout
  localparam int CTRL_ARM_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int ST_EMUL_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_WDT_BIT = 2;
  localparam int ST_BOOT_BIT = 3;
  localparam int ST_PB5_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_DONE_BIT = 8;
  localparam int ST_REJECT_BIT = 9;

  // ==========================================
  // ahb-lite encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ==========================================
  // timing: least programming time per byte
  localparam int PROG_TIME_US = 4000;
  localparam int CLK_KHZ = 25000;
  localparam int PROG_CYCLES = (PROG_TIME_US * CLK_KHZ + 999) / 1000;

  // ==========================================
  // types
  typedef struct packed {
    logic emulation;
    logic irq_level;
    logic watchdog;
  } option_s;

  typedef struct packed {
    logic rc_osc;
    logic stop_disable;
    logic self_check;
  } legacy_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } bus_cmd_s;

  typedef enum logic [2:0] {
    PROG_IDLE = 3'b001,
    PROG_BURN = 3'b010,
    PROG_COMMIT = 3'b100
  } prog_state_e;

endpackage

// file: prog_timer.sv
// programming pulse timer for the option byte cell
`timescale 1ns/100ps
`default_nettype none
module prog_timer
  import option_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] count_reg;

  // ==========================================
  // down counter
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || abort_in) begin
      count_reg <= '0;
    end else if (start_in && !busy_out) begin
      count_reg <= CNT_LOAD;
    end else if (busy_out) begin
      count_reg <= count_reg - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || abort_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      busy_out <= (start_in && !busy_out) || (busy_out && count_reg != CNT_ONE);
      done_out <= busy_out && count_reg == CNT_ONE;
    end
  end

endmodule
`default_nettype wire

// file: option_decode.sv
// registered decode of the option byte into block controls
`timescale 1ns/100ps
`default_nettype none
module option_decode
  import option_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [OPT_W-1:0] option_byte_in,
  input wire logic boot_active_in,
  input wire legacy_s legacy_in,
  output option_s opt_out,
  output legacy_s legacy_out
);

  // ==========================================
  // decode; upper bits never looked at
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      opt_out <= '0;
      legacy_out <= '0;
    end else begin
      opt_out.emulation <= option_byte_in[OPT_EMUL_BIT];
      opt_out.irq_level <= option_byte_in[OPT_IRQ_BIT];
      opt_out.watchdog <= option_byte_in[OPT_WDT_BIT] && !boot_active_in;
      // legacy options vanish in emulation
      legacy_out <= option_byte_in[OPT_EMUL_BIT] ? '0 : legacy_in;
    end
  end

endmodule
`default_nettype wire

// file: option_byte_decode.sv
// option byte store, decoder and ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module option_byte_decode
  import option_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // host core side
  input wire logic bootloader_active_in,
  input wire logic port_b_bit5_in,
  input wire logic rc_osc_sel_in,
  input wire logic stop_disable_sel_in,
  input wire logic self_check_req_in,
  // decoded controls
  output logic emulation_mode_out,
  output logic irq_level_sense_out,
  output logic watchdog_enable_out,
  output logic rc_osc_option_out,
  output logic stop_disable_option_out,
  output logic self_check_enable_out
);

  // ==========================================
  // declarations
  logic [OPT_W-1:0] option_reg;
  logic [OPT_W-1:0] pending_reg;
  logic [OPT_W-1:0] pending_next;
  logic [31:0] ctrl_reg;
  logic done_flag_reg;
  logic reject_flag_reg;
  logic pb5_meta_reg;
  logic pb5_sync_reg;
  logic [31:0] rdata_next;
  logic [ADDR_W-1:0] opt_addr;
  logic addr_phase;
  logic wr_phase;
  logic wr_option;
  logic wr_ctrl;
  logic wr_status;
  logic prog_ok;
  logic prog_start;
  logic prog_abort;
  logic timer_busy;
  logic timer_done;
  logic set_done;
  logic set_reject;
  bus_cmd_s cmd_reg;
  option_s opt_dec;
  legacy_s legacy_req;
  legacy_s legacy_dec;
  prog_state_e prog_state_reg;
  prog_state_e prog_state_next;

  // ==========================================
  // pin synchroniser
  // the pin is not on the core clock
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pb5_meta_reg <= 1'b0;
      pb5_sync_reg <= 1'b0;
    end else begin
      pb5_meta_reg <= port_b_bit5_in;
      pb5_sync_reg <= pb5_meta_reg;
    end
  end

  // ==========================================
  // address map follows the personality
  assign opt_addr = opt_dec.emulation ? OPT_ADDR_EMUL : OPT_ADDR_NATIVE;

  // ==========================================
  // address phase capture
  assign addr_phase = hsel_in && hready_in && htrans_in[1];

  // the data phase needs the address phase that led it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_reg <= '0;
    end else if (hready_in) begin
      cmd_reg.valid <= addr_phase;
      cmd_reg.write <= hwrite_in;
      cmd_reg.addr <= haddr_in[ADDR_W-1:0];
    end
  end

  // ==========================================
  // read mux, sampled at the address phase
  // unmapped offsets fall through and read as zero
  always_comb begin
    rdata_next = RDATA_ZERO;
    if (haddr_in[ADDR_W-1:0] == opt_addr) begin
      rdata_next[OPT_W-1:0] = option_reg;
    end else if (haddr_in[ADDR_W-1:0] == CTRL_ADDR) begin
      rdata_next = ctrl_reg;
    end else if (haddr_in[ADDR_W-1:0] == STATUS_ADDR) begin
      rdata_next[ST_EMUL_BIT] = opt_dec.emulation;
      rdata_next[ST_IRQ_BIT] = opt_dec.irq_level;
      rdata_next[ST_WDT_BIT] = opt_dec.watchdog;
      rdata_next[ST_BOOT_BIT] = bootloader_active_in;
      rdata_next[ST_PB5_BIT] = pb5_sync_reg;
      rdata_next[ST_BUSY_BIT] = prog_state_reg != PROG_IDLE;
      rdata_next[ST_DONE_BIT] = done_flag_reg;
      rdata_next[ST_REJECT_BIT] = reject_flag_reg;
    end
  end

  // read data stands in the data phase; zero wait states
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hrdata_out <= RDATA_ZERO;
    end else if (addr_phase && !hwrite_in) begin
      hrdata_out <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
    end else begin
      hreadyout_out <= 1'b1;
    end
  end

  // no error case exists, so the response stays okay
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hresp_out <= HRESP_OKAY;
    end else begin
      hresp_out <= HRESP_OKAY;
    end
  end

  // ==========================================
  // write data phase decode
  assign wr_phase = cmd_reg.valid && cmd_reg.write;
  assign wr_option = wr_phase && cmd_reg.addr == opt_addr;
  assign wr_ctrl = wr_phase && cmd_reg.addr == CTRL_ADDR;
  assign wr_status = wr_phase && cmd_reg.addr == STATUS_ADDR;

  // only a download in progress, armed and idle, may burn the cell
  assign prog_ok = bootloader_active_in && ctrl_reg[CTRL_ARM_BIT] && prog_state_reg == PROG_IDLE;
  assign prog_start = wr_option && prog_ok;
  assign prog_abort = prog_state_reg == PROG_BURN && !bootloader_active_in;
  assign set_reject = (wr_option && !prog_ok) || prog_abort;
  assign set_done = prog_state_reg == PROG_COMMIT;

  // ==========================================
  // control register
  // arming is a second key, so a stray write cannot start a burn
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= CTRL_RESET;
      ctrl_reg[CTRL_ARM_BIT] <= hwdata_in[CTRL_ARM_BIT];
    end
  end

  // ==========================================
  // sticky flags, write one to clear; a new event wins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      done_flag_reg <= 1'b0;
    end else if (set_done) begin
      done_flag_reg <= 1'b1;
    end else if (wr_status && hwdata_in[ST_DONE_BIT]) begin
      done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reject_flag_reg <= 1'b0;
    end else if (set_reject) begin
      reject_flag_reg <= 1'b1;
    end else if (wr_status && hwdata_in[ST_REJECT_BIT]) begin
      reject_flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // programming sequence
  // eprom cells only go from erased zero to one, so new data is or-ed in
  assign pending_next = option_reg | hwdata_in[OPT_W-1:0];

  always_comb begin
    prog_state_next = prog_state_reg;
    case (prog_state_reg)
      PROG_IDLE: begin
        if (prog_start) begin
          prog_state_next = PROG_BURN;
        end
      end
      PROG_BURN: begin
        if (prog_abort) begin
          prog_state_next = PROG_IDLE;
        end else if (timer_done) begin
          prog_state_next = PROG_COMMIT;
        end
      end
      PROG_COMMIT: begin
        prog_state_next = PROG_IDLE;
      end
      default: begin
        prog_state_next = PROG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prog_state_reg <= PROG_IDLE;
    end else begin
      prog_state_reg <= prog_state_next;
    end
  end

  // latched at start so later bus traffic cannot alter a burn
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pending_reg <= OPT_ERASED;
    end else if (prog_start) begin
      pending_reg <= pending_next;
    end
  end

  // ==========================================
  // option cell; old value reads until the burn completes
  // reset stands in for the erased cell at power-up
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      option_reg <= OPT_ERASED;
    end else if (prog_state_reg == PROG_COMMIT) begin
      option_reg <= pending_reg;
    end
  end

  prog_timer #(
    .CYCLES(PROG_TIME_CYCLES)
  ) u_prog_timer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(prog_start),
    .abort_in(prog_abort),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // ==========================================
  // decode
  assign legacy_req.rc_osc = rc_osc_sel_in;
  assign legacy_req.stop_disable = stop_disable_sel_in;
  assign legacy_req.self_check = self_check_req_in;

  option_decode u_option_decode (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .option_byte_in(option_reg),
    .boot_active_in(bootloader_active_in),
    .legacy_in(legacy_req),
    .opt_out(opt_dec),
    .legacy_out(legacy_dec)
  );

  // ==========================================
  // outputs, all from decoder flops
  assign emulation_mode_out = opt_dec.emulation;
  assign irq_level_sense_out = opt_dec.irq_level;
  assign watchdog_enable_out = opt_dec.watchdog;
  assign rc_osc_option_out = legacy_dec.rc_osc;
  assign stop_disable_option_out = legacy_dec.stop_disable;
  assign self_check_enable_out = legacy_dec.self_check;

  // timer busy mirrors the burn state; left unused, the status busy bit comes from prog_state_reg
  logic busy_unused;
  assign busy_unused = timer_busy;

endmodule
`default_nettype wire

// file: option_byte_decode_properties.sv
// assertion checker for the option byte decoder
`timescale 1ns/100ps
`default_nettype none
module option_byte_decode_props
  import option_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic bootloader_active_in,
  input wire logic rc_osc_sel_in,
  input wire logic emulation_mode_out,
  input wire logic irq_level_sense_out,
  input wire logic watchdog_enable_out,
  input wire logic rc_osc_option_out,
  input wire logic stop_disable_option_out,
  input wire logic self_check_enable_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // bus
  zero_wait_a: assert property (hreadyout_out)
    else $error("wait state seen");
  okay_resp_a: assert property (hresp_out == HRESP_OKAY)
    else $error("response not okay");
  opt_upper_a: assert property (hsel_in && hready_in && htrans_in[1] && !hwrite_in &&
    haddr_in[11:0] == OPT_ADDR_NATIVE |=> hrdata_out[31:8] == 24'h0) else $error("upper read bits set");
  // ==========================================
  // decode
  // the store only ever gains ones, so decoded emulation and irq level never drop outside reset
  no_unprogram_a: assert property (!$fell(emulation_mode_out) && !$fell(irq_level_sense_out))
    else $error("decoded option dropped");
  prog_boot_a: assert property ($rose(emulation_mode_out) |-> $past(bootloader_active_in, 3))
    else $error("option changed outside bootloader");
  wdt_boot_gate_a: assert property (watchdog_enable_out |-> !$past(bootloader_active_in))
    else $error("watchdog on during bootloader");
  rc_block_a: assert property (emulation_mode_out |=> !rc_osc_option_out)
    else $error("rc option in emulation");
  stop_block_a: assert property (emulation_mode_out |=> !stop_disable_option_out)
    else $error("stop disable in emulation");
  check_block_a: assert property (emulation_mode_out |=> !self_check_enable_out)
    else $error("self check in emulation");
  legacy_pass_a: assert property (rc_osc_sel_in && !emulation_mode_out ##1 !emulation_mode_out |->
    rc_osc_option_out) else $error("rc option lost in native");
  cover property ($rose(emulation_mode_out));
  cover property ($rose(watchdog_enable_out));
  cover property ($rose(irq_level_sense_out));
endmodule
bind option_byte_decode option_byte_decode_props #(
  .PROG_TIME_CYCLES(PROG_TIME_CYCLES)
) u_props (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hready_in(hready_in),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .hrdata_out(hrdata_out),
  .bootloader_active_in(bootloader_active_in),
  .rc_osc_sel_in(rc_osc_sel_in),
  .emulation_mode_out(emulation_mode_out),
  .irq_level_sense_out(irq_level_sense_out),
  .watchdog_enable_out(watchdog_enable_out),
  .rc_osc_option_out(rc_osc_option_out),
  .stop_disable_option_out(stop_disable_option_out),
  .self_check_enable_out(self_check_enable_out)
);
`default_nettype wire

// file: option_byte_decode_tb_top.sv
// self-checking testbench for the option byte decoder
`timescale 1ns/100ps
`default_nettype none
module option_byte_decode_tb_top;
  import option_pkg::*;
  // short burn keeps the run brief
  localparam int PT = 8;
  logic sys_clk_in, rst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic bootloader_active_in, port_b_bit5_in, rc_osc_sel_in, stop_disable_sel_in, self_check_req_in;
  logic emulation_mode_out, irq_level_sense_out, watchdog_enable_out;
  logic rc_osc_option_out, stop_disable_option_out, self_check_enable_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  int n_errors, n_checks, cycles;
  option_byte_decode #(
    .PROG_TIME_CYCLES(PT)
  ) u_option_byte_decode (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .hrdata_out(hrdata_out),
    .bootloader_active_in(bootloader_active_in),
    .port_b_bit5_in(port_b_bit5_in),
    .rc_osc_sel_in(rc_osc_sel_in),
    .stop_disable_sel_in(stop_disable_sel_in),
    .self_check_req_in(self_check_req_in),
    .emulation_mode_out(emulation_mode_out),
    .irq_level_sense_out(irq_level_sense_out),
    .watchdog_enable_out(watchdog_enable_out),
    .rc_osc_option_out(rc_osc_option_out),
    .stop_disable_option_out(stop_disable_option_out),
    .self_check_enable_out(self_check_enable_out)
  );
  // single slave, so its ready is the bus ready
  assign hready_in = hreadyout_out;
  always #20 sys_clk_in = ~sys_clk_in;
  // ==========================================
  // hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================
  // tasks
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic outs(input logic [5:0] exp);
    chk({26'h0, emulation_mode_out, irq_level_sense_out, watchdog_enable_out, rc_osc_option_out,
      stop_disable_option_out, self_check_enable_out}, {26'h0, exp});
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel_in <= 1'b1;
    haddr_in <= {20'h0, a};
    hwrite_in <= wr;
    htrans_in <= HTRANS_NONSEQ;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= HTRANS_IDLE;
    hwdata_in <= wd;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_done();
    int i;
    rd = 32'h0;
    for (i = 0; i < 40 && rd[ST_DONE_BIT] !== 1'b1; i++) begin
      xfer(1'b0, STATUS_ADDR, 32'h0);
    end
    chk({31'h0, rd[ST_DONE_BIT]}, 32'h1);
    xfer(1'b1, STATUS_ADDR, 32'h100);
  endtask
  // ==========================================
  // tests
  initial begin
    sys_clk_in = 1'b0;
    rst_in = 1'b1;
    {hsel_in, hwrite_in, bootloader_active_in, port_b_bit5_in} = 4'h0;
    {rc_osc_sel_in, stop_disable_sel_in, self_check_req_in} = 3'h7;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    htrans_in = HTRANS_IDLE;
    hsize_in = 3'h2;
    {n_errors, n_checks, cycles} = 0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd_chk(OPT_ADDR_NATIVE, 32'h0);
    rd_chk(STATUS_ADDR, 32'h0);
    rd_chk(12'h100, 32'h0);
    outs(6'b000111);
    $display("test 1 done");
    xfer(1'b1, CTRL_ADDR, 32'h1);
    rd_chk(CTRL_ADDR, 32'h1);
    xfer(1'b1, OPT_ADDR_NATIVE, 32'h7);
    repeat (PT + 4) @(posedge sys_clk_in);
    rd_chk(OPT_ADDR_NATIVE, 32'h0);
    rd_chk(STATUS_ADDR, 32'h200);
    xfer(1'b1, STATUS_ADDR, 32'h200);
    $display("test 2 done");
    bootloader_active_in <= 1'b1;
    port_b_bit5_in <= 1'b1;
    xfer(1'b1, OPT_ADDR_NATIVE, 32'hfb);
    rd_chk(OPT_ADDR_NATIVE, 32'h0);
    rd_chk(STATUS_ADDR, 32'h38);
    wait_done();
    rd_chk(OPT_ADDR_NATIVE, 32'hfb);
    outs(6'b010111);
    rd_chk(STATUS_ADDR, 32'h1a);
    bootloader_active_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    outs(6'b011111);
    stop_disable_sel_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    outs(6'b011101);
    stop_disable_sel_in <= 1'b1;
    $display("test 3 done");
    bootloader_active_in <= 1'b1;
    xfer(1'b1, OPT_ADDR_NATIVE, 32'h4);
    wait_done();
    outs(6'b110000);
    rd_chk(OPT_ADDR_EMUL, 32'hff);
    rd_chk(OPT_ADDR_NATIVE, 32'h0);
    // losing the bootloader mid-burn must abort and flag it
    xfer(1'b1, OPT_ADDR_EMUL, 32'h0);
    bootloader_active_in <= 1'b0;
    repeat (PT + 4) @(posedge sys_clk_in);
    rd_chk(STATUS_ADDR, 32'h217);
    outs(6'b111000);
    $display("test 4 done");
    final_report();
  end
endmodule
`default_nettype wire
